// *** hw/event_status_and_interrupt_logic.v ***
/*
  Event status and interrupt logic: collects bus and engine events into a
  16-bit event status word, keeps the fault cause register, checks
  programming faults and drives prioritised A/B interrupt requests with
  release on acknowledge. Assumes the message engine pulses its event
  inputs for one cycle on mclk_in and that the host acknowledge input is
  already synchronous (registered by the host side logic).
*/
// Overview of operation
// - End of message from flag or block done
// - End of message interrupts need mask bit 12
// - Fault sets event and cause; host clears
// - Cause bits 15..13: mode, gap, timeout
// - Cause bits 12..10: count, command, direction
// - Cause bits 9..6: flags, count, frame, base
// - Zero base at start: flag, still start
// - Cause bits 4..0: terminals, pointers, control, broadcast, latency
// - Status word and mask overlap raises event
// - Page end raises event, next page
// - Ring end raises event, wrap to start
// - Stop bit: cease, raise event, go off
// - Monitor lock on valid, lost on invalid
// - Illegal command raises event, message error
// - Command matching trigger word sets bit 6
// - Mode code in multi terminal sets bit 5
// - Retry success and retry failed events
// - Switch bus on qualified second command
// - Switchover posts bit 3, no gap, no errors
// - Self-test failure and loop compare events
// - Bus bit zero for A, one for B
// - A vector first; release on acknowledge
// - Two masks select A and B events
`timescale 1ns/10ps
`default_nettype none
`include "evt_defs.vh"

module event_status_and_interrupt_logic (
  input wire mclk_in,
  input wire rst_in,
  // Register port
  input wire [`ADDR_W-1:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rdata_out,
  // Message engine events
  input wire msg_done_in,
  input wire eom_flag_in,
  input wire msg_bus_b_in,
  input wire [15:0] rx_status_in,
  input wire status_valid_in,
  input wire cmd_valid_in,
  input wire cmd_bus_b_in,
  input wire [15:0] rx_command_in,
  input wire cmd_illegal_in,
  input wire mode_code_done_in,
  input wire page_end_in,
  input wire ring_end_in,
  input wire stop_bit_in,
  input wire msg_valid_in,
  input wire msg_invalid_in,
  input wire retry_ok_in,
  input wire retry_fail_in,
  input wire engine_busy_in,
  input wire [15:0] term_ctrl_in,
  input wire target_bus_disabled_in,
  input wire selftest_fail_in,
  input wire loop_mismatch_in,
  input wire xmit_err_in,
  input wire dma_err_in,
  // Programming fault checks from the engine
  input wire start_cmd_in,
  input wire mode_request_in,
  input wire mode_invalid_in,
  input wire [15:0] gap_cycles_in,
  input wire [4:0] resp_timeout_in,
  input wire wcount_mismatch_in,
  input wire hostcmd_invalid_in,
  input wire [1:0] dir_bits_in,
  input wire saflag_conflict_in,
  input wire zero_count_in,
  input wire frame_short_in,
  input wire no_new_base_in,
  input wire [15:0] control_block_base_in,
  input wire [7:0] term_count_in,
  input wire ring_ptr_bad_in,
  input wire sim_broadcast_in,
  input wire latency_over_in,
  input wire term_cw_check_in,
  // Interrupt acknowledge
  input wire iack_in,
  // Outputs
  output reg irq_a_out,
  output reg irq_b_out,
  output reg [15:0] vector_out,
  output reg vector_valid_out,
  output reg msg_error_out,
  output reg stop_off_out,
  output reg start_out,
  output reg locked_out,
  output reg switch_bus_out,
  output reg gap_invalid_out,
  output reg inhibit_err_out,
  output reg ring_wrap_out,
  output reg page_next_out
);

  // Register file state
  reg [15:0] status_reg, status_next;
  reg [15:0] fault_reg, fault_next;
  reg [15:0] mask_a_reg, mask_b_reg;
  reg [15:0] vec_a_reg, vec_b_reg;
  reg [15:0] stmask_reg, trig_reg;
  reg [2:0] ctrl_reg;
  reg pend_a_reg, pend_b_reg;
  reg [15:0] ev_set, pf_set;
  reg sw_now;

  wire bc_mode = ctrl_reg[`CTL_BC_MODE];
  wire mon_mode = ctrl_reg[`CTL_MON_MODE];

  // Register port address match, used by both write and read decoding
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Bus switchover qualification
  always @* begin
    sw_now = engine_busy_in && cmd_valid_in && (cmd_bus_b_in != msg_bus_b_in) &&
             (term_ctrl_in[`TCW_SIM] || term_ctrl_in[`TCW_MON]) &&
             term_ctrl_in[`TCW_SWITCH] && !target_bus_disabled_in;
  end

  // Programming fault causes
  always @* begin
    pf_set = `ZERO16;
    pf_set[`PF_MODE] = mode_request_in && mode_invalid_in;
    pf_set[`PF_GAP] = start_cmd_in && bc_mode && (gap_cycles_in < `GAP_MIN_CYC);
    pf_set[`PF_TIMEOUT] = start_cmd_in && (resp_timeout_in != 5'h00) &&
                          (resp_timeout_in < `TIMEOUT_MIN);
    pf_set[`PF_WCOUNT] = wcount_mismatch_in;
    pf_set[`PF_HOSTCMD] = hostcmd_invalid_in;
    pf_set[`PF_DIR] = bc_mode && (&dir_bits_in);
    pf_set[`PF_SAFLAG] = saflag_conflict_in;
    pf_set[`PF_ZCOUNT] = zero_count_in;
    pf_set[`PF_FRAME] = frame_short_in;
    pf_set[`PF_NOBASE] = no_new_base_in;
    pf_set[`PF_ZBASE] = start_cmd_in && (control_block_base_in == `ZERO16);
    pf_set[`PF_NOTERM] = start_cmd_in && mon_mode && (term_count_in == 8'h00);
    pf_set[`PF_RINGPTR] = start_cmd_in && ring_ptr_bad_in;
    pf_set[`PF_TERMCW] = term_cw_check_in &&
                         !(term_ctrl_in[`TCW_SIM] || term_ctrl_in[`TCW_MON]);
    pf_set[`PF_SIMBC] = sim_broadcast_in;
    pf_set[`PF_LATENCY] = latency_over_in;
  end

  // Event collection
  always @* begin
    ev_set = `ZERO16;
    ev_set[`EV_XMIT_ERR] = xmit_err_in;
    ev_set[`EV_DMA_ERR] = dma_err_in;
    ev_set[`EV_PAGE_FULL] = page_end_in;
    ev_set[`EV_EOM] = bc_mode ? msg_done_in : (msg_done_in && eom_flag_in);
    ev_set[`EV_PROG_ERR] = |pf_set;
    ev_set[`EV_STMASK] = (bc_mode && status_valid_in && |(rx_status_in & stmask_reg)) ||
                         ring_end_in;
    ev_set[`EV_STOP] = bc_mode && stop_bit_in;
    ev_set[`EV_LOCK_LOST] = mon_mode && locked_out && msg_invalid_in;
    ev_set[`EV_ILLEGAL] = cmd_illegal_in;
    ev_set[`EV_TRIGGER] = cmd_valid_in && (rx_command_in == trig_reg);
    ev_set[`EV_MODE_CODE] = mon_mode && mode_code_done_in;
    ev_set[`EV_RETRY_OK] = retry_ok_in;
    ev_set[`EV_RETRY_FAIL] = retry_fail_in || sw_now;
    ev_set[`EV_SELFTEST] = selftest_fail_in;
    ev_set[`EV_LOOP_CMP] = loop_mismatch_in;
  end

  // Next values: hardware set wins over a host clear in the same cycle
  always @* begin
    status_next = status_reg;
    fault_next = fault_reg;
    if (wr_in && hit(addr_in, `OFF_STATUS)) begin
      status_next = wdata_in;
    end
    if (wr_in && hit(addr_in, `OFF_FAULT)) begin
      fault_next = wdata_in;
    end
    if (msg_done_in || sw_now) begin
      status_next[`EV_BUS_B] = sw_now ? cmd_bus_b_in : msg_bus_b_in;
    end
    status_next = status_next | ev_set;
    fault_next = fault_next | pf_set;
  end

  // Status, fault and host-written registers
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg <= `ZERO16;
      fault_reg <= `ZERO16;
      mask_a_reg <= `ZERO16;
      mask_b_reg <= `ZERO16;
      vec_a_reg <= `ZERO16;
      vec_b_reg <= `ZERO16;
      stmask_reg <= `ZERO16;
      trig_reg <= `ZERO16;
      ctrl_reg <= 3'b000;
    end else begin
      status_reg <= status_next;
      fault_reg <= fault_next;
      if (wr_in) begin
        if (hit(addr_in, `OFF_MASK_A)) mask_a_reg <= wdata_in;
        if (hit(addr_in, `OFF_MASK_B)) mask_b_reg <= wdata_in;
        if (hit(addr_in, `OFF_VEC_A)) vec_a_reg <= wdata_in;
        if (hit(addr_in, `OFF_VEC_B)) vec_b_reg <= wdata_in;
        if (hit(addr_in, `OFF_STMASK)) stmask_reg <= wdata_in;
        if (hit(addr_in, `OFF_TRIG)) trig_reg <= wdata_in;
        if (hit(addr_in, `OFF_CTRL)) ctrl_reg <= wdata_in[2:0];
      end
      if (stop_bit_in && bc_mode) begin
        ctrl_reg[`CTL_RUN] <= 1'b0;
      end
    end
  end

  // Interrupt pending: new masked events raise, acknowledge releases.
  // A takes priority so B waits for a second acknowledge.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
      vector_out <= `ZERO16;
      vector_valid_out <= 1'b0;
      irq_a_out <= 1'b0;
      irq_b_out <= 1'b0;
    end else begin
      vector_valid_out <= 1'b0;
      if (iack_in && pend_a_reg) begin
        vector_out <= vec_a_reg;
        vector_valid_out <= 1'b1;
        pend_a_reg <= |(ev_set & mask_a_reg);
        pend_b_reg <= pend_b_reg | |(ev_set & mask_b_reg);
      end else if (iack_in && pend_b_reg) begin
        vector_out <= vec_b_reg;
        vector_valid_out <= 1'b1;
        pend_a_reg <= |(ev_set & mask_a_reg);
        pend_b_reg <= |(ev_set & mask_b_reg);
      end else begin
        pend_a_reg <= pend_a_reg | |(ev_set & mask_a_reg);
        pend_b_reg <= pend_b_reg | |(ev_set & mask_b_reg);
      end
      irq_a_out <= pend_a_reg && !(iack_in && pend_a_reg);
      irq_b_out <= pend_b_reg && !(iack_in && !pend_a_reg);
    end
  end

  // Engine-facing responses
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      msg_error_out <= 1'b0;
      stop_off_out <= 1'b0;
      start_out <= 1'b0;
      locked_out <= 1'b0;
      switch_bus_out <= 1'b0;
      gap_invalid_out <= 1'b0;
      inhibit_err_out <= 1'b0;
      ring_wrap_out <= 1'b0;
      page_next_out <= 1'b0;
    end else begin
      msg_error_out <= cmd_illegal_in;
      stop_off_out <= bc_mode && stop_bit_in;
      start_out <= start_cmd_in;
      ring_wrap_out <= ring_end_in;
      page_next_out <= page_end_in;
      switch_bus_out <= sw_now;
      if (msg_valid_in) begin
        locked_out <= mon_mode;
      end else if (msg_invalid_in) begin
        locked_out <= 1'b0;
      end
      // Held until the switched message ends, so the gap and errors stay off
      if (sw_now) begin
        gap_invalid_out <= 1'b1;
        inhibit_err_out <= 1'b1;
      end else if (msg_done_in) begin
        gap_invalid_out <= 1'b0;
        inhibit_err_out <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= `ZERO16;
    end else if (rd_in) begin
      case (1'b1)
        hit(addr_in, `OFF_STATUS): rdata_out <= status_reg;
        hit(addr_in, `OFF_FAULT): rdata_out <= fault_reg;
        hit(addr_in, `OFF_MASK_A): rdata_out <= mask_a_reg;
        hit(addr_in, `OFF_MASK_B): rdata_out <= mask_b_reg;
        hit(addr_in, `OFF_VEC_A): rdata_out <= vec_a_reg;
        hit(addr_in, `OFF_VEC_B): rdata_out <= vec_b_reg;
        hit(addr_in, `OFF_STMASK): rdata_out <= stmask_reg;
        hit(addr_in, `OFF_TRIG): rdata_out <= trig_reg;
        hit(addr_in, `OFF_CTRL): rdata_out <= {13'h0000, ctrl_reg};
        hit(addr_in, `OFF_STATE): rdata_out <= {12'h000, pend_b_reg, pend_a_reg,
                                                locked_out, gap_invalid_out};
        default: rdata_out <= `ZERO16;
      endcase
    end else begin
      rdata_out <= `ZERO16;
    end
  end

endmodule
`default_nettype wire

// *** include/evt_defs.vh ***
/*
  Constants for the event status and interrupt logic: register offsets,
  event bit positions, fault cause positions and timing figures.
  Assumes inclusion by bare name from design files.
*/
`ifndef EVT_DEFS_VH
`define EVT_DEFS_VH

// Register offsets (word index on the plain register port)
`define ADDR_W 4
`define OFF_STATUS 4'h0
`define OFF_FAULT 4'h1
`define OFF_MASK_A 4'h2
`define OFF_MASK_B 4'h3
`define OFF_VEC_A 4'h4
`define OFF_VEC_B 4'h5
`define OFF_STMASK 4'h6
`define OFF_TRIG 4'h7
`define OFF_CTRL 4'h8
`define OFF_STATE 4'h9

// Event status word bit positions
`define EV_XMIT_ERR 15
`define EV_DMA_ERR 14
`define EV_PAGE_FULL 13
`define EV_EOM 12
`define EV_PROG_ERR 11
`define EV_STMASK 10
`define EV_RING_FULL 10
`define EV_STOP 9
`define EV_LOCK_LOST 8
`define EV_ILLEGAL 7
`define EV_TRIGGER 6
`define EV_MODE_CODE 5
`define EV_RETRY_OK 4
`define EV_RETRY_FAIL 3
`define EV_SWITCH 3
`define EV_SELFTEST 2
`define EV_LOOP_CMP 1
`define EV_BUS_B 0

// Fault cause bit positions
`define PF_MODE 15
`define PF_GAP 14
`define PF_TIMEOUT 13
`define PF_WCOUNT 12
`define PF_HOSTCMD 11
`define PF_DIR 10
`define PF_SAFLAG 9
`define PF_ZCOUNT 8
`define PF_FRAME 7
`define PF_NOBASE 6
`define PF_ZBASE 5
`define PF_NOTERM 4
`define PF_RINGPTR 3
`define PF_TERMCW 2
`define PF_SIMBC 1
`define PF_LATENCY 0

// Terminal control word bits
`define TCW_SWITCH 11
`define TCW_SIM 9
`define TCW_MON 8
// Control register bits
`define CTL_MON_MODE 0
`define CTL_BC_MODE 1
`define CTL_RUN 2

// Timing figures
`define GAP_MIN_US 30
`define CLK_MHZ 200
// Minimum gap in clock cycles, sized to match the gap input
`define GAP_MIN_CYC 16'h1770
`define TIMEOUT_MIN 5'h07
`define PAGE_LAST 16'hFFFF
`define ZERO16 16'h0000

`endif

// *** verification/event_status_and_interrupt_logic_bench.sv ***
/*
  Self-checking bench for the event status and interrupt logic.
  Assumes the design, checker and host model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module event_status_and_interrupt_logic_bench;
  logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000, rx_status_in = 16'h0000, rx_command_in = 16'h0000;
  logic [15:0] term_ctrl_in = 16'h0000, gap_cycles_in = 16'h1770, control_block_base_in = 16'h0001;
  logic [4:0] resp_timeout_in = 5'h00;
  logic [1:0] dir_bits_in = 2'h0;
  logic [7:0] term_count_in = 8'h01;
  logic eom_flag_in = 1, msg_bus_b_in = 0, cmd_bus_b_in = 0, engine_busy_in = 0;
  logic target_bus_disabled_in = 0;
  logic [28:0] p = '0;
  wire term_cw_check_in, ring_ptr_bad_in, mode_invalid_in, mode_request_in, cmd_valid_in;
  wire status_valid_in, msg_invalid_in, msg_valid_in, start_cmd_in, latency_over_in;
  wire sim_broadcast_in, no_new_base_in, frame_short_in, zero_count_in, saflag_conflict_in;
  wire hostcmd_invalid_in, wcount_mismatch_in, msg_done_in, dma_err_in, xmit_err_in;
  wire loop_mismatch_in, selftest_fail_in, retry_fail_in, retry_ok_in, mode_code_done_in;
  wire cmd_illegal_in, stop_bit_in, ring_end_in, page_end_in, iack_in;
  wire [15:0] rdata_out, vector_out;
  wire irq_a_out, irq_b_out, vector_valid_out, msg_error_out, stop_off_out, start_out;
  wire locked_out, switch_bus_out, gap_invalid_out, inhibit_err_out, ring_wrap_out, page_next_out;
  int err_total = 0, total_checks = 0, cyc = 0;
  int sb[12] = '{13, 10, 9, 7, 5, 4, 3, 2, 1, 15, 14, 12};
  int fb[8] = '{12, 11, 9, 8, 7, 6, 1, 0};
  // One pulse bit per event input
  assign {term_cw_check_in, ring_ptr_bad_in, mode_invalid_in, mode_request_in, cmd_valid_in,
    status_valid_in, msg_invalid_in, msg_valid_in, start_cmd_in, latency_over_in,
    sim_broadcast_in, no_new_base_in, frame_short_in, zero_count_in, saflag_conflict_in,
    hostcmd_invalid_in, wcount_mismatch_in, msg_done_in, dma_err_in, xmit_err_in,
    loop_mismatch_in, selftest_fail_in, retry_fail_in, retry_ok_in, mode_code_done_in,
    cmd_illegal_in, stop_bit_in, ring_end_in, page_end_in} = p;
  event_status_and_interrupt_logic event_status_and_interrupt_logic_i (.*);
  host_iack_model host_iack_model_i (.mclk_in(mclk_in), .rst_in(rst_in), .irq_a_in(irq_a_out),
    .irq_b_in(irq_b_out), .vector_in(vector_out), .vector_valid_in(vector_valid_out),
    .iack_out(iack_in));
  always #2.5 mclk_in = ~mclk_in;
  // Hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1;
    @(posedge mclk_in);
    wr_in <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge mclk_in);
    rd_in <= 0;
    #1 d = rdata_out;
  endtask
  task automatic pulse(input logic [28:0] v);
    @(posedge mclk_in);
    p <= v;
    @(posedge mclk_in);
    p <= '0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    int i;
    logic [15:0] d, va, vb, r, e;
    void'($urandom(63));
    repeat (16) @(posedge mclk_in);
    rst_in <= 0;
    rd(1, d); chk("fault", 16'h0000, d);
    rd(4'hF, d); chk("unmapped", 16'h0000, d);
    // Masks, vectors and compare words keep what the host wrote
    for (i = 2; i < 8; i++) begin
      r = 16'($urandom);
      wr(4'(i), r);
      rd(4'(i), d); chk("reg", r, d);
    end
    va = 16'($urandom);
    vb = va ^ 16'h5A5A;
    wr(4, va); wr(5, vb);
    // Twelve single-input events on both levels, then two acknowledges
    for (i = 0; i < 12; i++) begin
      wr(8, (i == 2) ? 16'h0002 : 16'h0001);
      wr(2, 16'h0001 << sb[i]); wr(3, 16'h0001 << sb[i]);
      pulse(29'(1) << i);
      #1 chk("pulse_out", (i < 4) ? (16'h0008 >> i) : 16'h0000,
             {page_next_out, ring_wrap_out, stop_off_out, msg_error_out});
      @(posedge mclk_in);
      #1 chk("irq_a", 16'h0001, irq_a_out); chk("irq_b", 16'h0001, irq_b_out);
      for (int k = 0; k < 100 && host_iack_model_i.vq.size() < 2; k++) @(posedge mclk_in);
      chk("vec_a", va, host_iack_model_i.vq.pop_front());
      chk("vec_b", vb, host_iack_model_i.vq.pop_front());
      rd(0, d); chk("status", 16'h0001 << sb[i], d);
      wr(0, 16'h0000);
    end
    // Message done without end flag, on bus B
    wr(2, 16'hEFFE); wr(3, 16'h0000);
    eom_flag_in <= 0; msg_bus_b_in <= 1;
    pulse(29'h0000_0800);
    rd(0, d); chk("bus_b", 16'h0001, d);
    wr(0, 16'h0000);
    eom_flag_in <= 1; msg_bus_b_in <= 0;
    pulse(29'h0000_0800);
    @(posedge mclk_in);
    #1 chk("irq_eom", 16'h0000, irq_a_out);
    rd(0, d); chk("eom", 16'h1000, d);
    wr(2, 16'h0000); wr(0, 16'h0000);
    // Lock then loss
    pulse(29'h0020_0000);
    #1 chk("locked", 16'h0001, locked_out);
    pulse(29'h0040_0000);
    rd(0, d); chk("lock_lost", 16'h0100, d);
    wr(0, 16'h0000); wr(8, 16'h0002);
    // Status mask and trigger, mismatch then match
    for (i = 0; i < 2; i++) begin
      r = 16'($urandom) | 16'h0001;
      wr(6, r); wr(7, r);
      rx_status_in <= i ? r : ~r; rx_command_in <= i ? r : ~r;
      pulse(29'h0180_0000);
      rd(0, d); chk("match", i ? 16'h0440 : 16'h0000, d);
      wr(0, 16'h0000);
    end
    // Second command on the other bus while busy
    wr(8, 16'h0001);
    engine_busy_in <= 1; term_ctrl_in <= 16'h0A00; cmd_bus_b_in <= 1; rx_command_in <= ~r;
    pulse(29'h0100_0000);
    #1 chk("switch_out", 16'h0003, {switch_bus_out, inhibit_err_out});
    rd(9, d); chk("gap_inv", 16'h0001, d & 16'h0001);
    rd(0, d); chk("switch", 16'h0008, d & 16'hFFFE);
    engine_busy_in <= 0; term_ctrl_in <= 16'h0000;
    wr(0, 16'h0000);
    // Zero base start, then every pulsed fault cause
    control_block_base_in <= 16'h0000;
    pulse(29'h0010_0000);
    #1 chk("start", 16'h0001, start_out);
    control_block_base_in <= 16'h0001;
    e = 16'h8024;
    for (i = 0; i < 8; i++) begin
      pulse(29'(1) << (12 + i));
      e = e | (16'h0001 << fb[i]);
    end
    pulse(29'h0600_0000);
    pulse(29'h1000_0000);
    rd(1, d); chk("fault", e, d);
    rd(0, d); chk("prog_err", 16'h0800, d);
    wr(1, 16'h0000);
    rd(1, d); chk("fault_clr", 16'h0000, d);
    // Start at the legal limits of gap and timeout, then below them
    wr(8, 16'h0003); resp_timeout_in <= 5'h07;
    pulse(29'h0010_0000);
    rd(1, d); chk("fault_edge", 16'h0000, d);
    gap_cycles_in <= 16'h0010; resp_timeout_in <= 5'h03;
    term_count_in <= 8'h00; dir_bits_in <= 2'h3;
    pulse(29'h0810_0000);
    rd(1, d); chk("fault_lvl", 16'h6418, d);
    end_sim();
  end
endmodule
`default_nettype wire

// *** verification/evt_chk.sv ***
/*
  Checker for the event status and interrupt logic.
  Assumes one clock, mclk_in, and an asynchronous high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module evt_chk (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic page_end_in,
  input wire logic ring_end_in,
  input wire logic stop_bit_in,
  input wire logic cmd_illegal_in,
  input wire logic start_cmd_in,
  input wire logic [15:0] control_block_base_in,
  input wire logic msg_invalid_in,
  input wire logic cmd_valid_in,
  input wire logic [15:0] term_ctrl_in,
  input wire logic target_bus_disabled_in,
  input wire logic iack_in,
  input wire logic irq_a_out,
  input wire logic irq_b_out,
  input wire logic vector_valid_out,
  input wire logic page_next_out,
  input wire logic ring_wrap_out,
  input wire logic stop_off_out,
  input wire logic msg_error_out,
  input wire logic start_out,
  input wire logic locked_out,
  input wire logic switch_bus_out,
  input wire logic gap_invalid_out,
  input wire logic inhibit_err_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  AST_PAGE_NEXT: assert property (page_end_in |=> page_next_out)
    else $error("page end without next page pulse");
  AST_RING_WRAP: assert property (ring_end_in |=> ring_wrap_out)
    else $error("ring end without wrap pulse");
  AST_STOP_OFF: assert property (stop_bit_in |=> stop_off_out)
    else $error("stop bit without off pulse");
  AST_ILLEGAL_ERR: assert property (cmd_illegal_in |=> msg_error_out)
    else $error("illegal command without message error");
  AST_ZERO_BASE: assert property (start_cmd_in && control_block_base_in == 16'h0000 |=> start_out)
    else $error("zero base start not attempted");
  AST_LOCK_LOST: assert property (msg_invalid_in |=> !locked_out)
    else $error("lock kept after invalid message");
  AST_ACK_A_FIRST: assert property (iack_in && irq_a_out && irq_b_out
    |=> vector_valid_out && !irq_a_out && irq_b_out)
    else $error("acknowledge did not serve level A first");
  AST_VEC_CAUSE: assert property (vector_valid_out |-> $past(iack_in && (irq_a_out || irq_b_out)))
    else $error("vector without acknowledge");
  AST_SWITCH_QUAL: assert property (switch_bus_out
    |-> $past(cmd_valid_in && term_ctrl_in[11] && !target_bus_disabled_in))
    else $error("switchover without qualified command");
  AST_SWITCH_POST: assert property (switch_bus_out |-> gap_invalid_out && inhibit_err_out)
    else $error("switchover without gap and error inhibit");
endmodule
bind event_status_and_interrupt_logic evt_chk evt_chk_i (.*);
`default_nettype wire

// *** verification/host_iack_model.sv ***
/*
  Host model servicing interrupt requests with acknowledge cycles.
  Assumes the block answers an acknowledge with a one-cycle vector strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module host_iack_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic irq_a_in,
  input wire logic irq_b_in,
  input wire logic [15:0] vector_in,
  input wire logic vector_valid_in,
  output logic iack_out
);
  logic [15:0] vq[$];
  // Random latency, so both prompt and slow service are seen
  initial begin
    iack_out = 1'b0;
    forever begin
      @(posedge mclk_in);
      if (!rst_in && (irq_a_in || irq_b_in)) begin
        repeat (2 + $urandom % 4) @(posedge mclk_in);
        iack_out <= 1'b1;
        @(posedge mclk_in);
        iack_out <= 1'b0;
        @(posedge mclk_in);
      end
    end
  end
  // Vector is taken only in the strobe cycle; vector_out holds it until the next acknowledge
  always @(posedge mclk_in) if (vector_valid_in) vq.push_back(vector_in);
endmodule
`default_nettype wire
